// *** rtl/slpt_core.sv ***
// Purpose: telegram receiver, register file and answer transmitter
// Assumes: i_supply_lvl is the digitised supply modulation, idle high
// Notes:   o_out idles high; answers start with a falling edge
//
// Functional notes
// RULE1 - sync bit length becomes the supply bit time of the telegram
// RULE2 - three command bits, unsigned, most significant first
// RULE3 - command parity one when command bits hold odd count of zeros
// RULE4 - four address bits, unsigned register code
// RULE5 - address parity one when address bits hold odd count of zeros
// RULE6 - fourteen data bits in the register's own format
// RULE7 - write keeps only the trailing bits matching register width
// RULE8 - read places the value in the leading data bits
// RULE9 - data parity one when data bits hold even count of zeros
// RULE10 - acknowledge zero pulse on output after each valid telegram
// RULE11 - read answer is acknowledge, fourteen data bits, data parity
// RULE12 - programmer raises programming voltage after acknowledge and delay
// RULE13 - code 2 reads, code 3 writes, unlisted codes undefined
// RULE14 - code 4 stores all working copies to nonvolatile, lock excluded
// RULE15 - code 5 erases all nonvolatile registers, lock excluded
// RULE16 - code 7 locks the device and disables programming
// RULE17 - unsigned values travel most significant bit first
// RULE18 - sign-magnitude: leading sign bit, then unsigned magnitude
// RULE19 - two's complement: leading zero positive, one negative
// RULE20 - address 7 reads live sample, writes ignored
// RULE21 - address 6 lock bit set only by lock command
// RULE22 - addresses 8, 9, 13 read only, never altered
// RULE23 - lower clamp takes 0 to 1023, upper clamp 0 to 2047
// RULE24 - zero: no change in bit; one: change at 50-80 percent
// RULE25 - order: sync, command, parity, address, parity, write data
// RULE26 - acknowledge only for a valid, processed telegram
// RULE27 - programmer uses 1.7-1.8 ms in, accepts 2-4 ms out
// RULE28 - wrong parity or undefined command discards, no acknowledge
// RULE29 - writes to unmapped or read-only addresses change nothing
`timescale 1ns/100ps
`default_nettype none
module slpt_core #(
    parameter int          OUT_BIT_CYCLES = slpt_pkg::OUT_BIT_CYC,
    parameter int          SYNC_MAX       = slpt_pkg::SYNC_MAX_CYC,
    parameter logic [4:0]  ZERO_TRIM      = 5'h00,
    parameter logic [4:0]  OSC_TRIM       = 5'h00,
    parameter logic [7:0]  FACTORY_SET    = 8'h00
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_supply_lvl,
    input  wire logic [13:0]       i_adc_sample,
    output logic                   o_out,
    output slpt_pkg::slpt_cfg_s    o_cfg,
    output slpt_pkg::slpt_cfg_s    o_nv_cfg,
    output logic                   o_locked
);
    localparam int ONE_AT = OUT_BIT_CYCLES * slpt_pkg::ONE_PCT / 100;
    localparam logic [slpt_pkg::TMR_W-1:0] SYNC_LIM = slpt_pkg::TMR_W'(SYNC_MAX);

    typedef enum {RX_IDLE, RX_SYNC, RX_BIT} slpt_rx_e;
    typedef enum {TX_IDLE, TX_BIT, TX_TAIL} slpt_tx_e;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic zeros_odd(input logic [13:0] v, input int n);
        logic p;
        p = 1'b0;
        for (int i = 0; i < 14; i++) begin
            if (i < n) begin
                p = p ^ ~v[i];
            end
        end
        return p;
    endfunction

    function automatic logic [13:0] read_val(input logic [3:0] adr,
                                             input slpt_pkg::slpt_cfg_s c,
                                             input logic lk,
                                             input logic [13:0] smp);
        logic [13:0] v;
        v = 14'h0000;
        case (adr)
            slpt_pkg::ADR_LO_CLAMP:  v = {c.lower_duty_clamp, 4'h0};
            slpt_pkg::ADR_HI_CLAMP:  v = {c.upper_duty_clamp, 3'h0};
            slpt_pkg::ADR_DUTY_ZERO: v = {c.duty_at_zero_field, 3'h0};
            slpt_pkg::ADR_SLOPE:     v = c.duty_slope;
            slpt_pkg::ADR_FILT_RNG:  v = {c.filter_range_setting, 8'h00};
            slpt_pkg::ADR_LOCK:      v = {lk, 13'h0000};
            slpt_pkg::ADR_SAMPLE:    v = smp;
            slpt_pkg::ADR_ZERO_TRIM: v = {ZERO_TRIM, 9'h000};
            slpt_pkg::ADR_OSC_TRIM:  v = {OSC_TRIM, 9'h000};
            slpt_pkg::ADR_TEMP_LIN:  v = {c.temp_coeff_linear, 8'h00};
            slpt_pkg::ADR_TEMP_QUAD: v = {c.temp_coeff_quadratic, 9'h000};
            slpt_pkg::ADR_FACTORY:   v = {FACTORY_SET, 6'h00};
            default:                 v = 14'h0000;
        endcase
        return v; // RULE8 RULE20 RULE22
    endfunction

    // ------------------------------------------------------------
    // supply line synchroniser and edge detect
    // ------------------------------------------------------------
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic edge_w;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sync3_r <= 1'b1;
        end else begin
            sync1_r <= i_supply_lvl;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign edge_w = sync2_r ^ sync3_r;

    // ------------------------------------------------------------
    // telegram receiver
    // ------------------------------------------------------------
    slpt_rx_e                   rx_st_r;
    logic [slpt_pkg::TMR_W-1:0] rx_cnt_r;
    logic [slpt_pkg::TMR_W-1:0] bit_time_r;
    logic                       mid_r;
    logic [23:0]                rx_sh_r;
    logic [4:0]                 rx_num_r;
    logic                       rx_done_r;
    logic                       tx_busy_w;
    logic [slpt_pkg::TMR_W-1:0] mid_lim_w;
    logic [slpt_pkg::TMR_W:0]   tmo_lim_w;
    logic [23:0]                sh_nxt;
    logic [4:0]                 num_nxt;
    logic                       last_w;

    // a change before 7/8 of the bit time is the mid-bit change of a one
    assign mid_lim_w = bit_time_r - (bit_time_r >> 3); // RULE24
    assign tmo_lim_w = {1'b0, bit_time_r} + {2'b00, bit_time_r[slpt_pkg::TMR_W-1:1]};
    assign sh_nxt    = {rx_sh_r[22:0], mid_r}; // RULE17
    assign num_nxt   = rx_num_r + 5'h01;
    // write telegrams carry data; all others end after address parity
    assign last_w    = (num_nxt == 5'(slpt_pkg::LONG_LEN))
                     || (num_nxt == 5'(slpt_pkg::SHORT_LEN)
                         && sh_nxt[8:6] != slpt_pkg::CMD_WRITE); // RULE25

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_st_r    <= RX_IDLE;
            rx_cnt_r   <= '0;
            bit_time_r <= '0;
            mid_r      <= 1'b0;
            rx_sh_r    <= '0;
            rx_num_r   <= 5'h00;
            rx_done_r  <= 1'b0;
        end else begin
            rx_done_r <= 1'b0;
            case (rx_st_r)
                RX_IDLE: begin
                    rx_cnt_r <= '0;
                    rx_num_r <= 5'h00;
                    mid_r    <= 1'b0;
                    if (edge_w && !tx_busy_w) begin
                        rx_st_r <= RX_SYNC;
                    end
                end
                RX_SYNC: begin
                    rx_cnt_r <= rx_cnt_r + 1'b1;
                    if (edge_w) begin
                        bit_time_r <= rx_cnt_r + 1'b1; // RULE1
                        rx_cnt_r   <= '0;
                        rx_st_r    <= RX_BIT;
                    end else if (rx_cnt_r >= SYNC_LIM) begin
                        rx_st_r <= RX_IDLE;
                    end
                end
                RX_BIT: begin
                    rx_cnt_r <= rx_cnt_r + 1'b1;
                    if (edge_w && rx_cnt_r < mid_lim_w) begin
                        // a second early change is no legal bit
                        if (mid_r) begin
                            rx_st_r <= RX_IDLE;
                        end
                        mid_r <= 1'b1; // RULE24
                    end else if (edge_w) begin
                        rx_sh_r  <= sh_nxt;
                        rx_num_r <= num_nxt;
                        rx_cnt_r <= '0;
                        mid_r    <= 1'b0;
                        if (last_w) begin
                            rx_done_r <= 1'b1;
                            rx_st_r   <= RX_IDLE;
                        end
                    end else if ({1'b0, rx_cnt_r} > tmo_lim_w) begin
                        rx_st_r <= RX_IDLE;
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // telegram check and execution
    // ------------------------------------------------------------
    logic [2:0]  cmd_w;
    logic        cpar_w;
    logic [3:0]  adr_w;
    logic        apar_w;
    logic [13:0] val_w;
    logic        dpar_w;
    logic        is_long_w;
    logic        cmd_ok_w;
    logic        par_ok_w;
    logic        exec_w;
    logic [13:0] rd_w;

    slpt_pkg::slpt_cfg_s cfg_r;
    slpt_pkg::slpt_cfg_s nv_r;
    logic                lock_r;
    logic                tx_go_r;
    logic [15:0]         tx_load_r;
    logic [4:0]          tx_len_r;

    assign is_long_w = (rx_num_r == 5'(slpt_pkg::LONG_LEN));
    assign cmd_w     = is_long_w ? rx_sh_r[23:21] : rx_sh_r[8:6]; // RULE2
    assign cpar_w    = is_long_w ? rx_sh_r[20] : rx_sh_r[5];
    assign adr_w     = is_long_w ? rx_sh_r[19:16] : rx_sh_r[4:1]; // RULE4
    assign apar_w    = is_long_w ? rx_sh_r[15] : rx_sh_r[0];
    assign val_w     = rx_sh_r[14:1]; // RULE6
    assign dpar_w    = rx_sh_r[0];

    always_comb begin
        case (cmd_w)
            slpt_pkg::CMD_READ:  cmd_ok_w = 1'b1; // RULE13
            slpt_pkg::CMD_WRITE: cmd_ok_w = !lock_r;
            slpt_pkg::CMD_STORE: cmd_ok_w = !lock_r;
            slpt_pkg::CMD_ERASE: cmd_ok_w = !lock_r;
            slpt_pkg::CMD_LOCK:  cmd_ok_w = !lock_r;
            default:             cmd_ok_w = 1'b0; // RULE28
        endcase
    end

    assign par_ok_w = (cpar_w == zeros_odd({11'h000, cmd_w}, slpt_pkg::CMD_W)) // RULE3
                   && (apar_w == zeros_odd({10'h000, adr_w}, slpt_pkg::ADR_W)) // RULE5
                   && (!is_long_w
                       || dpar_w == !zeros_odd(val_w, slpt_pkg::DAT_W)); // RULE9
    assign exec_w   = rx_done_r && par_ok_w && cmd_ok_w; // RULE26 RULE28
    assign rd_w     = read_val(adr_w, cfg_r, lock_r, i_adc_sample);

    // working copies; only trailing data bits are taken
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_r <= slpt_pkg::CFG_RST;
        end else if (exec_w && cmd_w == slpt_pkg::CMD_WRITE) begin
            case (adr_w)
                slpt_pkg::ADR_LO_CLAMP:  cfg_r.lower_duty_clamp     <= val_w[9:0]; // RULE7 RULE23
                slpt_pkg::ADR_HI_CLAMP:  cfg_r.upper_duty_clamp     <= val_w[10:0]; // RULE23
                slpt_pkg::ADR_DUTY_ZERO: cfg_r.duty_at_zero_field   <= val_w[10:0]; // RULE19
                slpt_pkg::ADR_SLOPE:     cfg_r.duty_slope           <= val_w; // RULE18
                slpt_pkg::ADR_FILT_RNG:  cfg_r.filter_range_setting <= val_w[5:0];
                slpt_pkg::ADR_TEMP_LIN:  cfg_r.temp_coeff_linear    <= val_w[5:0];
                slpt_pkg::ADR_TEMP_QUAD: cfg_r.temp_coeff_quadratic <= val_w[4:0];
                default:                 cfg_r <= cfg_r; // RULE20 RULE21 RULE22 RULE29
            endcase
        end
    end

    // nonvolatile copies; the lock bit is kept apart
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nv_r <= slpt_pkg::CFG_RST;
        end else if (exec_w && cmd_w == slpt_pkg::CMD_STORE) begin
            nv_r <= cfg_r; // RULE14
        end else if (exec_w && cmd_w == slpt_pkg::CMD_ERASE) begin
            nv_r <= slpt_pkg::CFG_RST; // RULE15
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock_r <= slpt_pkg::LOCK_RST;
        end else if (exec_w && cmd_w == slpt_pkg::CMD_LOCK) begin
            lock_r <= 1'b1; // RULE16 RULE21
        end
    end

    // answer frame: acknowledge zero, then data and parity for reads
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_go_r   <= 1'b0;
            tx_load_r <= 16'h0000;
            tx_len_r  <= 5'h00;
        end else begin
            tx_go_r <= exec_w; // RULE10
            if (exec_w && cmd_w == slpt_pkg::CMD_READ) begin
                tx_load_r <= {1'b0, rd_w, !zeros_odd(rd_w, slpt_pkg::DAT_W)}; // RULE11 RULE9
                tx_len_r  <= 5'(slpt_pkg::RESP_LEN);
            end else if (exec_w) begin
                tx_load_r <= 16'h0000;
                tx_len_r  <= 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // answer transmitter
    // ------------------------------------------------------------
    slpt_tx_e    tx_st_r;
    logic [16:0] tx_cnt_r;
    logic [15:0] tx_sh_r;
    logic [4:0]  tx_idx_r;
    logic        out_r;

    assign tx_busy_w = (tx_st_r != TX_IDLE) || tx_go_r;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_st_r  <= TX_IDLE;
            tx_cnt_r <= 17'h00000;
            tx_sh_r  <= 16'h0000;
            tx_idx_r <= 5'h00;
            out_r    <= 1'b1;
        end else begin
            case (tx_st_r)
                TX_IDLE: begin
                    out_r    <= 1'b1;
                    tx_cnt_r <= 17'h00000;
                    tx_idx_r <= 5'h00;
                    if (tx_go_r) begin
                        tx_sh_r <= tx_load_r;
                        out_r   <= 1'b0; // RULE10
                        tx_st_r <= TX_BIT;
                    end
                end
                TX_BIT: begin
                    tx_cnt_r <= tx_cnt_r + 17'h00001;
                    if (tx_cnt_r == 17'(ONE_AT - 1) && tx_sh_r[15]) begin
                        out_r <= !out_r; // RULE24
                    end
                    if (tx_cnt_r == 17'(OUT_BIT_CYCLES - 1)) begin
                        tx_cnt_r <= 17'h00000;
                        out_r    <= !out_r;
                        tx_sh_r  <= {tx_sh_r[14:0], 1'b0}; // RULE17
                        tx_idx_r <= tx_idx_r + 5'h01;
                        if (tx_idx_r == tx_len_r - 5'h01) begin
                            tx_st_r <= TX_TAIL;
                        end
                    end
                end
                TX_TAIL: begin
                    tx_cnt_r <= tx_cnt_r + 17'h00001;
                    if (tx_cnt_r == 17'(OUT_BIT_CYCLES - 1)) begin
                        out_r   <= 1'b1;
                        tx_st_r <= TX_IDLE;
                    end
                end
                default: tx_st_r <= TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_out    = out_r;
    assign o_cfg    = cfg_r;
    assign o_nv_cfg = nv_r;
    assign o_locked = lock_r;
endmodule
`default_nettype wire

// *** rtl/slpt_pkg.sv ***
// Purpose: constants and types of the supply-line programming telegram block
// Assumes: core clock of 20 MHz
// Notes:   widths, codes, register map, timing counts
package slpt_pkg;
    // ------------------------------------------------------------
    // telegram layout
    // ------------------------------------------------------------
    localparam int CMD_W     = 3;
    localparam int ADR_W     = 4;
    localparam int DAT_W     = 14;
    localparam int SHORT_LEN = 9;
    localparam int LONG_LEN  = 24;
    localparam int RESP_LEN  = 16;

    localparam logic [2:0] CMD_READ  = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h3;
    localparam logic [2:0] CMD_STORE = 3'h4;
    localparam logic [2:0] CMD_ERASE = 3'h5;
    localparam logic [2:0] CMD_LOCK  = 3'h7;

    // ------------------------------------------------------------
    // register map and widths
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_LO_CLAMP  = 4'h1;
    localparam logic [3:0] ADR_HI_CLAMP  = 4'h2;
    localparam logic [3:0] ADR_DUTY_ZERO = 4'h3;
    localparam logic [3:0] ADR_SLOPE     = 4'h4;
    localparam logic [3:0] ADR_FILT_RNG  = 4'h5;
    localparam logic [3:0] ADR_LOCK      = 4'h6;
    localparam logic [3:0] ADR_SAMPLE    = 4'h7;
    localparam logic [3:0] ADR_ZERO_TRIM = 4'h8;
    localparam logic [3:0] ADR_OSC_TRIM  = 4'h9;
    localparam logic [3:0] ADR_TEMP_LIN  = 4'hB;
    localparam logic [3:0] ADR_TEMP_QUAD = 4'hC;
    localparam logic [3:0] ADR_FACTORY   = 4'hD;

    typedef struct packed {
        logic [9:0]  lower_duty_clamp;
        logic [10:0] upper_duty_clamp;
        logic [10:0] duty_at_zero_field;
        logic [13:0] duty_slope;
        logic [5:0]  filter_range_setting;
        logic [5:0]  temp_coeff_linear;
        logic [4:0]  temp_coeff_quadratic;
    } slpt_cfg_s;

    localparam slpt_cfg_s CFG_RST  = '0;
    localparam logic      LOCK_RST = 1'b0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ      = 20000;
    localparam int OUT_BIT_US   = 3000;
    localparam int OUT_BIT_CYC  = OUT_BIT_US * CLK_KHZ / 1000;
    localparam int ONE_PCT      = 65;
    localparam int SYNC_MAX_US  = 10000;
    localparam int SYNC_MAX_CYC = SYNC_MAX_US * CLK_KHZ / 1000;
    localparam int TMR_W        = 18;
endpackage

// *** verif/slpt_core_sva.sv ***
// Purpose: port checks of the supply-line telegram block
// Assumes: o_out idles high, every answer opens with a falling edge
// Notes:   bound into slpt_core
`timescale 1ns/100ps
`default_nettype none
module slpt_sva #(
    parameter int OUT_BIT_CYCLES = 40
) (
    input wire logic                i_core_clk,
    input wire logic                i_rst_n,
    input wire logic                i_supply_lvl,
    input wire logic                o_out,
    input wire slpt_pkg::slpt_cfg_s o_cfg,
    input wire slpt_pkg::slpt_cfg_s o_nv_cfg,
    input wire logic                o_locked
);
    logic [19:0] sup_q_r;
    logic [19:0] hi_r;
    logic [19:0] lo_r;
    logic        sup_d_r;
    logic        ack_r;
    // cycles since the supply line last moved
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sup_d_r <= 1'b1;
            sup_q_r <= 20'h0;
        end else begin
            sup_d_r <= i_supply_lvl;
            sup_q_r <= (i_supply_lvl != sup_d_r) ? 20'h0 : sup_q_r + 20'(sup_q_r != 20'hFFFFF);
        end
    end
    // high and low run lengths of the output; a fall after a long high run is an acknowledge
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hi_r  <= 20'h0;
            lo_r  <= 20'h0;
            ack_r <= 1'b0;
        end else if (o_out) begin
            hi_r  <= hi_r + 20'(hi_r != 20'hFFFFF);
            lo_r  <= 20'h0;
            ack_r <= 1'b0;
        end else begin
            hi_r <= 20'h0;
            lo_r <= lo_r + 20'h1;
            if (hi_r > 20'(OUT_BIT_CYCLES + 4)) begin
                ack_r <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence ack_start_s;
        $fell(o_out) && hi_r > 20'(OUT_BIT_CYCLES + 4);
    endsequence
    sequence ack_end_s;
        ack_r && o_out;
    endsequence
    ack_length_a: assert property (ack_end_s |-> lo_r == 20'(OUT_BIT_CYCLES))
        else $error("acknowledge low time wrong");
    ack_cause_a: assert property (ack_start_s |-> sup_q_r < 20'h10)
        else $error("acknowledge without a telegram");
    out_idle_a: assert property (sup_q_r > 20'(17 * OUT_BIT_CYCLES + 8) |-> o_out)
        else $error("output not idle long after telegram");
    lock_sticky_a: assert property ($past(o_locked) |-> o_locked)
        else $error("lock bit cleared");
    lock_cfg_a: assert property ($past(o_locked) |-> $stable(o_cfg))
        else $error("working copy changed while locked");
    lock_nv_a: assert property ($past(o_locked) |-> $stable(o_nv_cfg))
        else $error("stored copy changed while locked");
    nv_source_a: assert property (
        $changed(o_nv_cfg) |-> o_nv_cfg == $past(o_cfg) || o_nv_cfg == '0)
        else $error("stored copy not from working copy or erase");
    store_keeps_a: assert property (!$stable(o_nv_cfg) |-> $stable({o_cfg, o_locked}))
        else $error("store disturbed working copy or lock");
    lock_only_a: assert property ($rose(o_locked) |-> $stable(o_cfg) ##[0:16] !o_out)
        else $error("lock set without lock telegram");
    cfg_cause_a: assert property (!$stable(o_cfg) |-> sup_q_r < 20'h10 ##[0:16] !o_out)
        else $error("working copy changed without acknowledged write");
endmodule
bind slpt_core slpt_sva #(.OUT_BIT_CYCLES(OUT_BIT_CYCLES)) u_slpt_sva (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_supply_lvl(i_supply_lvl), .o_out(o_out),
    .o_cfg(o_cfg), .o_nv_cfg(o_nv_cfg), .o_locked(o_locked));
`default_nettype wire

// *** verif/slpt_prog.sv ***
// Purpose: programmer model that modulates the supply line and reads the answer
// Assumes: supply bit time of T cycles, one toggle at 65 percent for a one
// Notes:   line idles high; answer decoded against the measured acknowledge length
`timescale 1ns/100ps
`default_nettype none
module slpt_prog #(
    parameter int T = 20
) (
    input  wire logic i_core_clk,
    input  wire logic i_out,
    output logic      o_sup
);
    initial o_sup = 1'b1;
    task automatic tog(input int n);
        repeat (n) @(posedge i_core_clk);
        o_sup <= ~o_sup;
    endtask
    task automatic xfer(input logic [2:0] cmd, input logic [3:0] adr, input logic [13:0] val,
                        input logic [2:0] bad, output logic ack, output logic [14:0] ans,
                        output int len);
        logic [23:0] tel;
        int          nb;
        logic        v0;
        tel = {cmd, ~^cmd ^ bad[2], adr, ^adr ^ bad[1], val, ~^val ^ bad[0]};
        nb  = (cmd == slpt_pkg::CMD_WRITE) ? 24 : 9;
        ack = 1'b0;
        ans = '0;
        len = 0;
        tog(1);
        tog(T);
        for (int i = 23; i > 23 - nb; i--) begin
            if (tel[i]) begin
                tog(13);
                tog(T - 13);
            end else begin
                tog(T);
            end
        end
        for (int i = 0; i < 200 && !ack; i++) begin
            @(posedge i_core_clk);
            ack = !i_out;
        end
        if (ack) begin
            while (!i_out && len < 1000) begin
                @(posedge i_core_clk);
                len++;
            end
            for (int i = 14; i >= 0 && cmd == slpt_pkg::CMD_READ; i--) begin
                repeat (2) @(posedge i_core_clk);
                v0 = i_out;
                repeat (len - 4) @(posedge i_core_clk);
                ans[i] = (i_out != v0);
                repeat (2) @(posedge i_core_clk);
            end
            repeat (2 * len) @(posedge i_core_clk);
        end
    endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: self-checking bench of the telegram block
// Assumes: answer bit time shortened to OUT_BIT cycles
// Notes:   all traffic goes through the programmer model
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int OUT_BIT = 40;
    logic                i_core_clk;
    logic                i_rst_n;
    logic                sup;
    logic [13:0]         i_adc_sample;
    logic                o_out;
    slpt_pkg::slpt_cfg_s o_cfg;
    slpt_pkg::slpt_cfg_s o_nv_cfg;
    slpt_pkg::slpt_cfg_s saved;
    logic                o_locked;
    logic                ack;
    logic [14:0]         ans;
    int                  len;
    int                  miscompares = 0;
    int                  n_checks = 0;
    logic [3:0]          t_adr [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hB, 4'hC};
    logic [13:0]         t_val [7] = '{14'h03FF, 14'h3FFF, 14'h0400, 14'h2001, 14'h003F,
                                       14'h3FE1, 14'h3F1F};
    int                  t_wid [7] = '{10, 11, 11, 14, 6, 6, 5};
    logic [3:0]          ro_adr [6] = '{4'h7, 4'h8, 4'h9, 4'hD, 4'h6, 4'hF};
    // trims and factory byte are arbitrary values
    slpt_core #(.OUT_BIT_CYCLES(OUT_BIT), .SYNC_MAX(2000), .ZERO_TRIM(5'h15), .OSC_TRIM(5'h0A),
                .FACTORY_SET(8'hA5)) u_slpt_core (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_supply_lvl(sup),
        .i_adc_sample(i_adc_sample), .o_out(o_out), .o_cfg(o_cfg), .o_nv_cfg(o_nv_cfg),
        .o_locked(o_locked));
    slpt_prog #(.T(20)) u_slpt_prog (.i_core_clk(i_core_clk), .i_out(o_out), .o_sup(sup));
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    task automatic wr(input logic [2:0] c, input logic [3:0] a, input logic [13:0] d,
                      input logic [2:0] bad, input logic exp_ack);
        u_slpt_prog.xfer(c, a, d, bad, ack, ans, len);
        chk("acknowledge", exp_ack, ack);
    endtask
    task automatic rd(input logic [3:0] a, input logic [13:0] e);
        wr(slpt_pkg::CMD_READ, a, 14'h0, 3'h0, 1'b1);
        chk("ack length", OUT_BIT, len);
        chk("read data", {e, ~^e}, ans);
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge i_core_clk);
        miscompares++;
        $display("[FAIL] watchdog expected end seen hang");
        stop_test();
    end
    initial begin
        i_rst_n      = 1'b0;
        i_adc_sample = 14'h2A5C;
        repeat (5) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        chk("reset outputs", {1'b1, 1'b0}, {o_out, o_locked});
        for (int i = 0; i < 7; i++) begin
            wr(slpt_pkg::CMD_WRITE, t_adr[i], t_val[i], 3'h0, 1'b1);
            rd(t_adr[i], 14'(t_val[i] << (14 - t_wid[i])));
        end
        chk("lower clamp", 10'h3FF, o_cfg.lower_duty_clamp);
        chk("upper clamp", 11'h7FF, o_cfg.upper_duty_clamp);
        $display("test write_read done");
        saved = o_cfg;
        foreach (ro_adr[i]) wr(slpt_pkg::CMD_WRITE, ro_adr[i], 14'h3FFF, 3'h0, 1'b1);
        chk("config after ro writes", saved, o_cfg);
        chk("lock after write", 1'b0, o_locked);
        rd(4'h7, 14'h2A5C);
        rd(4'h8, {5'h15, 9'h0});
        rd(4'h9, {5'h0A, 9'h0});
        rd(4'hD, {8'hA5, 6'h0});
        rd(4'hF, 14'h0);
        $display("test read_only done");
        wr(slpt_pkg::CMD_READ, 4'h1, 14'h0, 3'h4, 1'b0);
        wr(slpt_pkg::CMD_READ, 4'h1, 14'h0, 3'h2, 1'b0);
        wr(slpt_pkg::CMD_WRITE, 4'h1, 14'h0001, 3'h1, 1'b0);
        foreach (ro_adr[i]) if (i < 3) wr(3'(i == 2 ? 6 : i), 4'h1, 14'h0, 3'h0, 1'b0);
        chk("config after refusals", saved, o_cfg);
        $display("test refused done");
        wr(slpt_pkg::CMD_STORE, 4'h0, 14'h0, 3'h0, 1'b1);
        chk("stored copy", saved, o_nv_cfg);
        wr(slpt_pkg::CMD_ERASE, 4'h0, 14'h0, 3'h0, 1'b1);
        chk("erased copy", 63'h0, o_nv_cfg);
        chk("lock after erase", 1'b0, o_locked);
        wr(slpt_pkg::CMD_STORE, 4'h5, 14'h0, 3'h0, 1'b1);
        $display("test store_erase done");
        wr(slpt_pkg::CMD_LOCK, 4'h0, 14'h0, 3'h0, 1'b1);
        chk("lock set", 1'b1, o_locked);
        wr(slpt_pkg::CMD_WRITE, 4'h1, 14'h0005, 3'h0, 1'b0);
        wr(slpt_pkg::CMD_ERASE, 4'h0, 14'h0, 3'h0, 1'b0);
        chk("config when locked", saved, o_cfg);
        chk("store when locked", saved, o_nv_cfg);
        rd(4'h6, 14'h2000);
        rd(4'h1, 14'h3FF0);
        $display("test lock done");
        stop_test();
    end
endmodule
`default_nettype wire
